// >>> core/rdc_consts.svh
// Purpose: constants for the rs485 driver-enable control block
// Assumes: included by bare name, guard prevents double use
// Notes: flag positions follow the configuration word layout
`ifndef RDC_CONSTS_SVH
`define RDC_CONSTS_SVH
// ----------------------------------------------------------------
// configuration word
// ----------------------------------------------------------------
`define RDC_FLAG_EN 0
`define RDC_FLAG_ON_SEND 1
`define RDC_FLAG_AFTER 2
`define RDC_FLAG_RXTX 4
`define RDC_FLAGS_RST 8'h00
`define RDC_FLAGS_AUTO 8'h03
`define RDC_DELAY_RST 16'h0000
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RDC_CLK_NS 10
`define RDC_MS_NS 1000000
`define RDC_MS_CYCLES (`RDC_MS_NS / `RDC_CLK_NS)
`define RDC_BAUD_DIV 868
`endif

// >>> core/rdc_pkg.sv
// Purpose: types and shared helpers for the driver-enable block
// Assumes: rdc_consts.svh available on the include path
// Notes: none
package rdc_pkg;
`include "rdc_consts.svh"
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_SEND, ST_POST} rdc_state_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic rdc_de_level(input logic [7:0] flags,
                                        input logic active);
    return (active && flags[`RDC_FLAG_EN]) ? flags[`RDC_FLAG_ON_SEND]
                                           : flags[`RDC_FLAG_AFTER];
  endfunction

  function automatic logic rdc_delay_done(input logic tick,
                                          input logic [15:0] cnt,
                                          input logic [15:0] lim);
    return tick && (cnt == lim - 16'h0001);
  endfunction
endpackage

// >>> core/rdc_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: in_ready_o is registered, so a full fifo stalls the source
`timescale 1ns/1ps
module rdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule // rdc_fifo

// >>> core/rdc_port_ctrl.sv
// Purpose: two uart ports with rs485 driver-enable and duplex control
// Assumes: inputs synchronous to ref_clk_i, 8N1 framing
// Notes: cfg_load_i applies flags and both delays in one cycle
`timescale 1ns/1ps
`include "rdc_consts.svh"
module rdc_port_ctrl
  import rdc_pkg::*;
#(
  parameter int NPORT = 2,
  parameter int MS_CYCLES = `RDC_MS_CYCLES,
  parameter int BAUD_DIV = `RDC_BAUD_DIV,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [NPORT-1:0] line_mode_strap_switch_i,
  input wire logic [NPORT-1:0] cfg_load_i,
  input wire logic [NPORT-1:0][7:0] cfg_flags_i,
  input wire logic [NPORT-1:0][15:0] cfg_pre_ms_i,
  input wire logic [NPORT-1:0][15:0] cfg_post_ms_i,
  input wire logic [NPORT-1:0][7:0] tx_data_i,
  input wire logic [NPORT-1:0] tx_valid_i,
  output logic [NPORT-1:0] tx_ready_o,
  output logic [NPORT-1:0][7:0] rx_data_o,
  output logic [NPORT-1:0] rx_valid_o,
  output logic [NPORT-1:0] txd_o,
  input wire logic [NPORT-1:0] rxd_i,
  output logic [NPORT-1:0] de_o,
  output logic [NPORT-1:0] rs485_on_o
);
  localparam int SW = $clog2(MS_CYCLES);

  for (genvar g = 0; g < NPORT; g++) begin : g_port
    logic [7:0] flags_q, fifo_data, rx_sh_q;
    logic [15:0] pre_q, post_q, ms_q, baud_q, rx_baud_q;
    logic strap_seen_q, tick, fifo_v, start, shifting_q;
    logic txd_q, de_q, rx_en, rx_busy_q, rx_valid_q;
    rdc_state_t st_q, st_d;
    logic [SW-1:0] sub_q;
    logic [8:0] shift_q;
    logic [3:0] bitn_q, rx_bit_q;
    logic [31:0] phase_len_q;

    // ----------------------------------------------------------------
    // configuration and power-up strap
    // ----------------------------------------------------------------
    // strap caught one edge after release, never under reset
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        flags_q <= `RDC_FLAGS_RST;
        pre_q <= `RDC_DELAY_RST;
        post_q <= `RDC_DELAY_RST;
        strap_seen_q <= 1'b0;
      end else begin
        strap_seen_q <= 1'b1;
        if (cfg_load_i[g]) begin
          flags_q <= cfg_flags_i[g];
          pre_q <= cfg_pre_ms_i[g];
          post_q <= cfg_post_ms_i[g];
        end else if (!strap_seen_q && !line_mode_strap_switch_i[g]) begin
          flags_q <= `RDC_FLAGS_AUTO;
          pre_q <= `RDC_DELAY_RST;
          post_q <= `RDC_DELAY_RST;
        end
      end
    end

    rdc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .in_data_i(tx_data_i[g]),
      .in_valid_i(tx_valid_i[g]),
      .in_ready_o(tx_ready_o[g]),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_v),
      .out_ready_i(start)
    );

    // ----------------------------------------------------------------
    // send sequencing
    // ----------------------------------------------------------------
    assign tick = (sub_q == SW'(MS_CYCLES - 1));
    assign start = (st_q == ST_SEND) && !shifting_q && fifo_v;

    always_comb begin
      st_d = st_q;
      unique case (st_q)
        ST_IDLE: begin
          if (fifo_v) begin
            st_d = (flags_q[`RDC_FLAG_EN] && pre_q != 16'h0000) ?
                   ST_PRE : ST_SEND;
          end
        end
        ST_PRE: begin
          if (rdc_delay_done(tick, ms_q, pre_q)) begin
            st_d = ST_SEND;
          end
        end
        ST_SEND: begin
          if (!shifting_q && !fifo_v) begin
            st_d = (flags_q[`RDC_FLAG_EN] && post_q != 16'h0000) ?
                   ST_POST : ST_IDLE;
          end
        end
        ST_POST: begin
          // fresh data during the hold reuses the asserted enable
          if (fifo_v) begin
            st_d = ST_SEND;
          end else if (rdc_delay_done(tick, ms_q, post_q)) begin
            st_d = ST_IDLE;
          end
        end
      endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        st_q <= ST_IDLE;
      end else begin
        st_q <= st_d;
      end
    end

    // ms base restarts on each phase so no delay is cut short
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        sub_q <= '0;
        ms_q <= 16'h0000;
      end else if (st_d != st_q) begin
        sub_q <= '0;
        ms_q <= 16'h0000;
      end else if (st_q == ST_PRE || st_q == ST_POST) begin
        sub_q <= tick ? '0 : sub_q + 1'b1;
        if (tick) begin
          ms_q <= ms_q + 16'h0001;
        end
      end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        de_q <= 1'b0;
      end else begin
        de_q <= rdc_de_level(flags_q, st_d != ST_IDLE);
      end
    end

    // ----------------------------------------------------------------
    // transmit shifter
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        shifting_q <= 1'b0;
        shift_q <= 9'h1ff;
        bitn_q <= 4'h0;
        baud_q <= 16'h0000;
        txd_q <= 1'b1;
      end else if (start) begin
        shifting_q <= 1'b1;
        shift_q <= {1'b1, fifo_data};
        bitn_q <= 4'h0;
        baud_q <= 16'h0000;
        txd_q <= 1'b0;
      end else if (shifting_q) begin
        if (baud_q == 16'(BAUD_DIV - 1)) begin
          baud_q <= 16'h0000;
          if (bitn_q == 4'h9) begin
            shifting_q <= 1'b0;
          end else begin
            txd_q <= shift_q[0];
            shift_q <= {1'b1, shift_q[8:1]};
            bitn_q <= bitn_q + 4'h1;
          end
        end else begin
          baud_q <= baud_q + 16'h0001;
        end
      end
    end

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    assign rx_en = !(flags_q[`RDC_FLAG_EN] && !flags_q[`RDC_FLAG_RXTX] &&
                     st_q != ST_IDLE);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        rx_busy_q <= 1'b0;
        rx_baud_q <= 16'h0000;
        rx_bit_q <= 4'h0;
        rx_sh_q <= 8'h00;
        rx_valid_q <= 1'b0;
      end else begin
        rx_valid_q <= 1'b0;
        if (!rx_en) begin
          rx_busy_q <= 1'b0;
        end else if (!rx_busy_q) begin
          if (!rxd_i[g]) begin
            rx_busy_q <= 1'b1;
            rx_baud_q <= 16'(BAUD_DIV / 2);
            rx_bit_q <= 4'h0;
          end
        end else if (rx_baud_q == 16'(BAUD_DIV - 1)) begin
          rx_baud_q <= 16'h0000;
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && rxd_i[g]) begin
            rx_busy_q <= 1'b0;
          end else if (rx_bit_q == 4'h9) begin
            rx_busy_q <= 1'b0;
            rx_valid_q <= rxd_i[g];
          end else if (rx_bit_q != 4'h0) begin
            rx_sh_q <= {rxd_i[g], rx_sh_q[7:1]};
          end
        end else begin
          rx_baud_q <= rx_baud_q + 16'h0001;
        end
      end
    end

    assign txd_o[g] = txd_q;
    assign de_o[g] = de_q;
    assign rx_data_o[g] = rx_sh_q;
    assign rx_valid_o[g] = rx_valid_q;
    assign rs485_on_o[g] = flags_q[`RDC_FLAG_EN];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        phase_len_q <= 32'h0;
      end else begin
        phase_len_q <= (st_d != st_q) ? 32'h0 : phase_len_q + 32'h1;
      end
    end

    a_off_de_idle: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      (!flags_q[`RDC_FLAG_EN] && $stable(flags_q)) |->
      de_q == flags_q[`RDC_FLAG_AFTER])
      else $error("driver enable moved while rs485 off");
    a_send_de_level: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      (st_q == ST_SEND && flags_q[`RDC_FLAG_EN] && $stable(flags_q)) |->
      de_q == flags_q[`RDC_FLAG_ON_SEND])
      else $error("wrong driver enable level while sending");
    a_idle_de_level: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      (st_q == ST_IDLE && $past(st_q) == ST_IDLE && $stable(flags_q)) |->
      de_q == flags_q[`RDC_FLAG_AFTER])
      else $error("wrong driver enable level when idle");
    a_half_rx_block: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      (flags_q[`RDC_FLAG_EN] && !flags_q[`RDC_FLAG_RXTX] &&
       st_q != ST_IDLE) |=> !rx_valid_q)
      else $error("byte received during half duplex send");
    a_pre_delay_len: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      (st_q == ST_PRE && st_d == ST_SEND) |->
      phase_len_q + 32'h1 == 32'(pre_q) * 32'(MS_CYCLES))
      else $error("pre-send delay length wrong");
    a_post_delay_len: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      (st_q == ST_POST && st_d == ST_IDLE) |->
      phase_len_q + 32'h1 == 32'(post_q) * 32'(MS_CYCLES))
      else $error("post-send hold length wrong");
    a_auto_defaults: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      ($rose(strap_seen_q) && !$past(cfg_load_i[g]) &&
       !$past(line_mode_strap_switch_i[g])) |->
      flags_q == `RDC_FLAGS_AUTO && pre_q == 16'h0 && post_q == 16'h0)
      else $error("auto activation defaults wrong");
    a_strap_on_off: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      ($rose(strap_seen_q) && !$past(cfg_load_i[g]) &&
       $past(line_mode_strap_switch_i[g])) |-> flags_q == `RDC_FLAGS_RST)
      else $error("rs485 activated with switch on");
    a_reset_de_idle: assert property (@(posedge ref_clk_i)
      disable iff (!reset_n_i)
      !strap_seen_q |-> (de_q == 1'b0 && txd_q))
      else $error("outputs not idle after reset");
  end
endmodule // rdc_port_ctrl

// >>> tb/rdc_line_model.sv
// Purpose: isolated line transceiver model for one port
// Assumes: driver enable active high, fail-safe bias idles the line high
// Notes: decodes 8N1 from the line, sends bytes to the receiver on demand
`timescale 1ns/1ps
module rdc_line_model #(
  parameter int BAUD = 8
) (
  input wire logic ref_clk_i,
  input wire logic txd_i,
  input wire logic de_i,
  output logic rxd_o,
  output logic [7:0] got_o,
  output int n_got_o
);
  // ----------------------------------------------------------------
  // line and decoder
  // ----------------------------------------------------------------
  logic line;
  logic [7:0] sh;
  // driver off leaves the bus to the bias, so polarity misuse goes silent
  assign line = de_i ? txd_i : 1'b1;
  initial begin
    rxd_o = 1'b1;
    got_o = 8'h00;
    n_got_o = 0;
    forever begin
      @(negedge ref_clk_i);
      if (!line) begin
        repeat (BAUD / 2) @(negedge ref_clk_i);
        for (int i = 0; i < 8; i++) begin
          repeat (BAUD) @(negedge ref_clk_i);
          sh[i] = line;
        end
        repeat (BAUD) @(negedge ref_clk_i);
        if (line) begin
          got_o = sh;
          n_got_o++;
        end
      end
    end
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk_i);
      rxd_o = fr[i];
      repeat (BAUD - 1) @(negedge ref_clk_i);
    end
  endtask
endmodule // rdc_line_model

// >>> tb/testbench.sv
// Purpose: self-checking bench for the driver-enable block
// Assumes: short ms and baud parameters, strap fixed from time zero
// Notes: port 0 strap off (auto), port 1 strap on
`timescale 1ns/1ps
module testbench;
  localparam int MS = 8;
  localparam int BD = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] strap = 2'b10;
  logic [1:0] load = '0;
  logic [1:0][7:0] flags = '0;
  logic [1:0][15:0] pre = '0;
  logic [1:0][15:0] post = '0;
  logic [1:0][7:0] tdat = '0;
  logic [1:0] tval = '0;
  logic [1:0] rdy, rval, txd, de, on;
  wire [1:0] rxd;
  logic [1:0][7:0] rdat;
  logic [7:0] got0, got1;
  int n_got0, n_got1, t00, t, n, n0;
  int n_fail = 0;
  int cmp_count = 0;
  int rx_n [2] = '{0, 0};
  logic [7:0] rx_last [2];
  always #5 clk = ~clk;
  rdc_port_ctrl #(.NPORT(2), .MS_CYCLES(MS), .BAUD_DIV(BD), .DEPTH(16))
    u_rdc_port_ctrl (.ref_clk_i(clk), .reset_n_i(rst_n),
    .line_mode_strap_switch_i(strap), .cfg_load_i(load),
    .cfg_flags_i(flags), .cfg_pre_ms_i(pre), .cfg_post_ms_i(post),
    .tx_data_i(tdat), .tx_valid_i(tval), .tx_ready_o(rdy),
    .rx_data_o(rdat), .rx_valid_o(rval), .txd_o(txd), .rxd_i(rxd),
    .de_o(de), .rs485_on_o(on));
  rdc_line_model #(.BAUD(BD)) u_rdc_line_model_0 (.ref_clk_i(clk),
    .txd_i(txd[0]), .de_i(de[0]), .rxd_o(rxd[0]), .got_o(got0),
    .n_got_o(n_got0));
  rdc_line_model #(.BAUD(BD)) u_rdc_line_model_1 (.ref_clk_i(clk),
    .txd_i(txd[1]), .de_i(de[1]), .rxd_o(rxd[1]), .got_o(got1),
    .n_got_o(n_got1));
  always @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (rval[p] === 1'b1) begin
        rx_n[p] <= rx_n[p] + 1;
        rx_last[p] <= rdat[p];
      end
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic give_up();
    n_fail++;
    finish_test();
  endtask
  // flags and both delays always travel together
  task automatic cfg(input int p, input logic [7:0] f,
                     input logic [15:0] a, input logic [15:0] b);
    @(negedge clk);
    load[p] = 1'b1;
    flags[p] = f;
    pre[p] = a;
    post[p] = b;
    @(negedge clk);
    load[p] = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic push(input int p, input logic [7:0] d);
    @(negedge clk);
    for (int k = 0; rdy[p] !== 1'b1; k++) begin
      if (k > 2000) give_up();
      @(negedge clk);
    end
    tval[p] = 1'b1;
    tdat[p] = d;
    @(negedge clk);
    tval[p] = 1'b0;
  endtask
  task automatic dur(input int p, input logic act, output int c);
    c = 0;
    for (int k = 0; de[p] !== act; k++) begin
      if (k > 2000) give_up();
      @(negedge clk);
    end
    while (de[p] === act) begin
      if (++c > 4000) give_up();
      @(negedge clk);
    end
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    chk(de, 2'b00);
    chk(txd, 2'b11);
    chk(rdy, 2'b00);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(on, 2'b01);
    chk(de, 2'b00);
    push(0, 8'ha5);
    dur(0, 1'b1, t00);
    chk(got0, 8'ha5);
    // delays add whole ms ticks to the enable window
    for (int i = 1; i < 3; i++) begin
      cfg(0, 8'h03, (i == 1) ? 16'h0002 : 16'h0000,
          (i == 2) ? 16'h0003 : 16'h0000);
      push(0, 8'h00);
      dur(0, 1'b1, t);
      chk(t - t00, (i == 1) ? 16 : 24);
    end
    cfg(0, 8'h05, 16'h0000, 16'h0000);
    chk(de[0], 1'b1);
    push(0, 8'h5a);
    dur(0, 1'b0, t);
    chk(t >= 10 * BD, 1'b1);
    chk(n_got0, 3);
    // disabled: enable stays at the idle level through a send
    for (int i = 0; i < 2; i++) begin
      cfg(0, (i == 0) ? 8'h04 : 8'h00, 16'h0000, 16'h0000);
      push(0, 8'h3c);
      repeat (40) @(negedge clk);
      chk(de[0], (i == 0));
      repeat (80) @(negedge clk);
      chk(n_got0, 4);
    end
    // a byte landing in the hold must not drop the enable
    cfg(0, 8'h03, 16'h0000, 16'h0003);
    fork
      push(0, 8'h11);
      begin
        repeat (90) @(negedge clk);
        push(0, 8'h22);
      end
      dur(0, 1'b1, t);
    join
    chk(t - t00, 24 + 90);
    repeat (4 * BD) @(negedge clk);
    chk(n_got0, 6);
    chk(got0, 8'h22);
    // 0xff leaves no low data bit to fake a start after tx ends
    for (int i = 0; i < 2; i++) begin
      cfg(0, (i == 0) ? 8'h03 : 8'h13, 16'h0000, 16'h0000);
      n0 = rx_n[0];
      fork
        push(0, 8'h81);
        begin
          repeat (10) @(negedge clk);
          u_rdc_line_model_0.send(8'hff);
        end
      join
      repeat (3 * BD) @(negedge clk);
      chk(rx_n[0] - n0, i);
    end
    chk(rx_last[0], 8'hff);
    u_rdc_line_model_1.send(8'h96);
    repeat (2 * BD) @(negedge clk);
    chk(rx_last[1], 8'h96);
    cfg(1, 8'h03, 16'h0000, 16'h0000);
    chk(on, 2'b11);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      tval[1] = rdy[1];
      tdat[1] = n[7:0];
      if (rdy[1] === 1'b1) n++;
    end
    chk(n >= 16 && n <= 17, 1'b1);
    chk(rdy[1], 1'b0);
    for (int k = 0; n_got1 != n; k++) begin
      if (k > 3000) give_up();
      @(negedge clk);
    end
    chk(got1, n - 1);
    chk(de[0], 1'b0);
    finish_test();
  end
endmodule // testbench
